// *** include/amc_pkg.sv ***
// Purpose: constants for the converter mode control register bank
// Assumes: one core clock, serial pins synchronised inside the block
// Notes: field positions follow the 24-bit register image, bit 23 sent first
// Summary of operation
// R1: a 24-bit mode register that the host writes and reads back serially.
// R2: register select code 001 reaches it; reset value is 0x080060.
// R3: transfers carry bit 23 first, down to bit 0, for reads and writes.
// R4: any mode write restarts modulator and filter and forces not-ready.
// R5: bits 9..0 set output rate; bits 19..18 select conversion clock source.
// R6: bits 23..21 select the converter operating mode.
// R7: status-append bit 20 makes each data read also send the status byte.
// R8: unused bits 17, 16, 14, 12 are written zero and read back zero.
// R9: not-ready clears when a new result lands and sets after a data read.
// R10: data read is 24 bits, or 32 bits with status appended.
// R11: status channel field names the channel of the held result.
// R12: with parity enabled, status parity flags an odd count of data ones.
package amc_pkg;
  localparam logic [23:0] MODE_RESET = 24'h08_0060;
  localparam logic [23:0] MODE_UNUSED_MASK = 24'h03_5000;
  localparam int MODE_MSB = 23;
  localparam int MD_LSB = 21;
  localparam int APPEND_BIT = 20;
  localparam int CLK_MSB = 19;
  localparam int CLK_LSB = 18;
  localparam int SINC_BIT = 15;
  localparam int PAR_BIT = 13;
  localparam int SINGLE_BIT = 11;
  localparam int REJ_BIT = 10;
  localparam int RATE_MSB = 9;
  localparam logic [2:0] RS_STATUS = 3'h0;
  localparam logic [2:0] RS_MODE = 3'h1;
  localparam logic [2:0] RS_DATA = 3'h3;
  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_RD_BIT = 6;
  localparam int CMD_RS_MSB = 5;
  localparam int CMD_RS_LSB = 3;
  localparam logic [5:0] LEN_CMD = 6'h08;
  localparam logic [5:0] LEN_STATUS = 6'h08;
  localparam logic [5:0] LEN_REG = 6'h18;
  localparam logic [5:0] LEN_DATA_STA = 6'h20;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam int ST_RDY = 7;
  localparam int ST_ERR = 6;
  localparam int ST_NOREF = 5;
  localparam int ST_PAR = 4;
  typedef enum logic [1:0] {PH_CMD, PH_WR, PH_RD, PH_SKIP} amc_phase_t;
endpackage : amc_pkg

// *** logic/amc_sync2.sv ***
// Purpose: two-stage synchroniser for asynchronous serial pins
// Assumes: inputs change independently of core_clk
// Notes: only the second stage is visible to the rest of the block
module amc_sync2 #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_level,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb
  begin
    next_meta = async_in;
    next_sync = meta;
  end

  // reset value comes from a constant tie at the instance, never a live pin
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta <= reset_level;
      sync_out <= reset_level;
    end
    else if (ce)
    begin
      meta <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule : amc_sync2

// *** logic/amc_mode_ctrl.sv ***
// Purpose: mode control register bank with serial register access
// Assumes: host samples dout on sclk rising edge, device changes it on falling edge
// Notes: command byte selects register; mode write restarts conversion path
module amc_mode_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  input wire logic result_valid,
  input wire logic [23:0] result_data,
  input wire logic [2:0] active_chan,
  input wire logic result_err,
  input wire logic ref_missing,
  output logic [2:0] conv_mode_sel,
  output logic append_status_en,
  output logic [1:0] clk_src_sel,
  output logic filter_type_sel,
  output logic parity_check_en,
  output logic single_cycle_en,
  output logic sixty_hz_notch_en,
  output logic [9:0] output_rate_code,
  output logic mod_filter_reset,
  output logic not_ready
);
  typedef struct packed {
    amc_pkg::amc_phase_t phase;
    logic [5:0] cnt;
    logic [31:0] shreg;
    logic sclk_q;
    logic [23:0] mode;
    logic [23:0] data;
    logic [7:0] status;
    logic mf_reset;
    logic dout;
    logic dout_oe;
    logic rd_is_data;
  } amc_state_t;

  // sclk history starts at its idle level so release of reset shows no false edge
  localparam amc_state_t STATE_RESET = '{
    phase: amc_pkg::PH_CMD, cnt: '0, shreg: '0, sclk_q: 1'b1,
    mode: amc_pkg::MODE_RESET, data: '0, status: amc_pkg::STATUS_RESET,
    mf_reset: 1'b0, dout: 1'b0, dout_oe: 1'b0, rd_is_data: 1'b0};

  amc_state_t s;
  amc_state_t next_s;
  logic [2:0] pins;
  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  logic sclk_rise;
  logic sclk_fall;
  logic [4:0] cmd_byte;
  logic [7:0] cmd_full;
  logic mode_wr_done;

  amc_sync2 #(.WIDTH(3)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .async_in({sclk, cs_n, din}),
    .reset_level(3'h6),
    .sync_out(pins)
  );

  assign sclk_s = pins[2];
  assign cs_n_s = pins[1];
  assign din_s = pins[0];
  assign sclk_rise = sclk_s && !s.sclk_q && !cs_n_s;
  assign sclk_fall = !sclk_s && s.sclk_q && !cs_n_s;
  assign cmd_full = {s.shreg[6:0], din_s};
  assign cmd_byte = cmd_full[7:3];

  // read-back image: unused bits are stored as zero so they return zero
  function automatic logic [31:0] read_image(input logic [2:0] rs, input amc_state_t st);
    logic [31:0] img;
    img = '0;
    case (rs)
      amc_pkg::RS_STATUS: img = {st.status, 24'h00_0000};
      amc_pkg::RS_MODE: img = {st.mode, 8'h00}; // R3
      amc_pkg::RS_DATA:
        img = {st.data, st.mode[amc_pkg::APPEND_BIT] ? st.status : 8'h00}; // R7
      default: img = '0;
    endcase
    return img;
  endfunction : read_image

  function automatic logic [5:0] read_len(input logic [2:0] rs, input logic append);
    logic [5:0] len;
    len = amc_pkg::LEN_REG;
    case (rs)
      amc_pkg::RS_STATUS: len = amc_pkg::LEN_STATUS;
      amc_pkg::RS_DATA: len = append ? amc_pkg::LEN_DATA_STA : amc_pkg::LEN_REG; // R10
      default: len = amc_pkg::LEN_REG;
    endcase
    return len;
  endfunction : read_len

  logic [2:0] sel_rs;
  logic sel_rd;
  assign sel_rs = cmd_full[amc_pkg::CMD_RS_MSB:amc_pkg::CMD_RS_LSB];
  assign sel_rd = cmd_full[amc_pkg::CMD_RD_BIT];
  assign mode_wr_done = (s.phase == amc_pkg::PH_WR) && sclk_rise && (s.cnt == 6'h01);

  always_comb
  begin
    next_s = s;
    next_s.sclk_q = sclk_s;
    next_s.mf_reset = 1'b0;
    // a new result updates data and status; mode write below overrides ready
    if (result_valid)
    begin
      next_s.data = result_data;
      next_s.status[amc_pkg::ST_RDY] = 1'b0; // R9
      next_s.status[amc_pkg::ST_ERR] = result_err;
      next_s.status[amc_pkg::ST_NOREF] = ref_missing;
      next_s.status[amc_pkg::ST_PAR] = s.mode[amc_pkg::PAR_BIT] & (^result_data); // R12
      next_s.status[2:0] = active_chan; // R11
    end
    if (cs_n_s)
    begin
      next_s.phase = amc_pkg::PH_CMD;
      next_s.cnt = '0;
      next_s.dout_oe = 1'b0;
    end
    else
    begin
      case (s.phase)
        amc_pkg::PH_CMD:
          if (sclk_rise)
          begin
            next_s.shreg = {s.shreg[30:0], din_s};
            next_s.cnt = s.cnt + 6'h01;
            if (s.cnt == amc_pkg::LEN_CMD - 6'h01)
            begin
              next_s.cnt = '0;
              if (cmd_byte[4] == 1'b0)
              begin
                if (sel_rd)
                begin
                  next_s.phase = amc_pkg::PH_RD;
                  next_s.shreg = read_image(sel_rs, s);
                  next_s.cnt = read_len(sel_rs, s.mode[amc_pkg::APPEND_BIT]);
                  next_s.dout_oe = 1'b1;
                  next_s.rd_is_data = (sel_rs == amc_pkg::RS_DATA);
                end
                else
                begin
                  // R2
                  next_s.phase = (sel_rs == amc_pkg::RS_MODE) ? amc_pkg::PH_WR : amc_pkg::PH_SKIP;
                  next_s.cnt = amc_pkg::LEN_REG;
                end
              end
            end
          end
        amc_pkg::PH_RD:
        begin
          if (sclk_fall)
          begin
            next_s.dout = s.shreg[31]; // R3
            next_s.shreg = {s.shreg[30:0], 1'b0};
          end
          if (sclk_rise)
          begin
            next_s.cnt = s.cnt - 6'h01;
            if (s.cnt == 6'h01)
            begin
              next_s.phase = amc_pkg::PH_CMD;
              next_s.cnt = '0;
              next_s.dout_oe = 1'b0;
              // a result landing in the same cycle wins over the read
              if (s.rd_is_data && !result_valid)
                next_s.status[amc_pkg::ST_RDY] = 1'b1; // R9
            end
          end
        end
        amc_pkg::PH_WR, amc_pkg::PH_SKIP:
          if (sclk_rise)
          begin
            next_s.shreg = {s.shreg[30:0], din_s}; // R3
            next_s.cnt = s.cnt - 6'h01;
            if (s.cnt == 6'h01)
            begin
              next_s.phase = amc_pkg::PH_CMD;
              next_s.cnt = '0;
              if (s.phase == amc_pkg::PH_WR)
              begin
                next_s.mode = {s.shreg[22:0], din_s} & ~amc_pkg::MODE_UNUSED_MASK; // R1 R8
                next_s.mf_reset = 1'b1; // R4
                next_s.status[amc_pkg::ST_RDY] = 1'b1; // R4
              end
            end
          end
        default: next_s.phase = amc_pkg::PH_CMD;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s <= STATE_RESET;
    else if (ce)
      s <= next_s;
  end

  assign conv_mode_sel = s.mode[amc_pkg::MODE_MSB:amc_pkg::MD_LSB]; // R6
  assign append_status_en = s.mode[amc_pkg::APPEND_BIT];
  assign clk_src_sel = s.mode[amc_pkg::CLK_MSB:amc_pkg::CLK_LSB]; // R5
  assign filter_type_sel = s.mode[amc_pkg::SINC_BIT];
  assign parity_check_en = s.mode[amc_pkg::PAR_BIT];
  assign single_cycle_en = s.mode[amc_pkg::SINGLE_BIT];
  assign sixty_hz_notch_en = s.mode[amc_pkg::REJ_BIT];
  assign output_rate_code = s.mode[amc_pkg::RATE_MSB:0]; // R5
  assign mod_filter_reset = s.mf_reset;
  assign not_ready = s.status[amc_pkg::ST_RDY];
  assign dout = s.dout;
  assign dout_oe = s.dout_oe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reset_value: assert property ($past(rst) |-> s.mode == amc_pkg::MODE_RESET) // R2
    else $error("mode register not at reset value after reset");
  a_write_restarts: assert property (ce && mode_wr_done |=> mod_filter_reset && not_ready) // R4
    else $error("mode write did not restart filter or set not-ready");
  a_restart_pulse: assert property (mod_filter_reset && ce |=> !mod_filter_reset) // R4
    else $error("filter restart longer than one cycle");
  a_unused_zero: assert property (ce && mode_wr_done |=> (s.mode & amc_pkg::MODE_UNUSED_MASK) == 24'h00_0000) // R8
    else $error("unused mode bits stored nonzero");
  a_mode_capture: assert property (ce && mode_wr_done |=> s.mode[amc_pkg::MODE_MSB] == $past(s.shreg[22])) // R3
    else $error("first serial bit not stored at bit 23");
  a_result_ready: assert property (ce && result_valid && !mode_wr_done |=> !not_ready) // R9
    else $error("new result did not clear not-ready");
  a_parity_flag: assert property (ce && result_valid && parity_check_en |=> s.status[amc_pkg::ST_PAR] == ^s.data) // R12
    else $error("parity flag wrong for stored result");
  a_result_chan: assert property (ce && result_valid |=> s.status[2:0] == $past(active_chan)) // R11
    else $error("channel field does not match result channel");
  a_data_len: assert property (ce && s.phase == amc_pkg::PH_CMD && !cs_n_s && sclk_rise && s.cnt == 6'h07
      && cmd_full[7:3] == {2'b01, amc_pkg::RS_DATA} |=> s.cnt == (append_status_en ? 6'h20 : 6'h18)) // R7 R10
    else $error("data read length wrong for append setting");
  a_rate_field: assert property (ce && mode_wr_done |=> output_rate_code == $past({s.shreg[8:0], din_s})) // R5
    else $error("rate code not taken from written bits");
  a_mode_field: assert property (ce && mode_wr_done |=> conv_mode_sel == $past(s.shreg[22:20])) // R6
    else $error("mode select not taken from written bits");
  c_mode_write: cover property (ce && mode_wr_done);
  c_data_read_32: cover property (s.phase == amc_pkg::PH_RD && s.cnt == 6'h20);
  c_result_land: cover property (ce && result_valid && append_status_en);
endmodule : amc_mode_ctrl

// *** tb/amc_host_model.sv ***
// Purpose: host side of the four-wire register link, drives framed transfers
// Assumes: sclk idles high, data changed while sclk is low, sampled on its rise
// Notes: half periods of 6 core cycles leave room for the pin synchronisers
module amc_host_model (
  input wire logic core_clk,
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // command byte then nbits of data; a short nbits aborts a transfer
  task automatic frame(input logic [7:0] cmd, input int nbits, input logic [31:0] wd, output logic [31:0] rd);
    int i;
    rd = 32'h0000_0000;
    cs_n = 1'b0;
    cyc(4);
    for (i = 0; i < 8 + nbits; i++)
    begin
      sclk = 1'b0;
      din = (i < 8) ? cmd[7 - i] : wd[nbits + 7 - i];
      cyc(6);
      if (i >= 8)
        rd = {rd[30:0], dout};
      sclk = 1'b1;
      cyc(6);
    end
    cs_n = 1'b1;
    // released line must not keep showing the last bit
    din = ~din;
    cyc(6);
  endtask : frame

  task automatic write_mode(input logic [23:0] m, input int nbits);
    logic [31:0] unused_rd;
    frame({2'b00, amc_pkg::RS_MODE, 3'b000}, nbits, {8'h00, m & ~amc_pkg::MODE_UNUSED_MASK}, unused_rd);
  endtask : write_mode
endmodule : amc_host_model

// *** tb/adc_mode_control_register_tb_top.sv ***
// Purpose: self-checking bench for the mode control register bank
// Assumes: host model speaks the serial link, bench drives the result port
// Notes: ce is held high throughout; freeze behaviour is not exercised
module adc_mode_control_register_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, din, dout, dout_oe, mod_filter_reset, not_ready;
  logic result_valid = 1'b0;
  logic [23:0] result_data = 24'h00_0000;
  logic [2:0] active_chan = 3'h0;
  logic result_err = 1'b0;
  logic ref_missing = 1'b0;
  logic [2:0] conv_mode_sel;
  logic append_status_en, filter_type_sel, parity_check_en, single_cycle_en, sixty_hz_notch_en;
  logic [1:0] clk_src_sel;
  logic [9:0] output_rate_code;
  logic [31:0] rd;
  int err_count = 0;
  int num_checks = 0;
  int pulses = 0;
  int p0;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (mod_filter_reset === 1'b1)
      pulses++;

  amc_host_model u_amc_host_model (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  amc_mode_ctrl u_amc_mode_ctrl (
    .core_clk(core_clk), .rst(rst), .ce(1'b1), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .result_valid(result_valid), .result_data(result_data), .active_chan(active_chan),
    .result_err(result_err), .ref_missing(ref_missing), .conv_mode_sel(conv_mode_sel),
    .append_status_en(append_status_en), .clk_src_sel(clk_src_sel), .filter_type_sel(filter_type_sel),
    .parity_check_en(parity_check_en), .single_cycle_en(single_cycle_en),
    .sixty_hz_notch_en(sixty_hz_notch_en), .output_rate_code(output_rate_code),
    .mod_filter_reset(mod_filter_reset), .not_ready(not_ready)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // field outputs packed in register order, unused bits dropped
  function automatic logic [19:0] fields(input logic [23:0] m);
    return {m[23:21], m[20], m[19:18], m[15], m[13], m[11], m[10], m[9:0]};
  endfunction : fields

  task automatic check_mode(input logic [23:0] m);
    chk({12'h000, conv_mode_sel, append_status_en, clk_src_sel, filter_type_sel, parity_check_en,
      single_cycle_en, sixty_hz_notch_en, output_rate_code}, {12'h000, fields(m)});
    u_amc_host_model.frame(8'h48, 24, 32'h0000_0000, rd);
    chk(rd, {8'h00, m});
  endtask : check_mode

  task automatic post_result(input logic [23:0] d, input logic [2:0] ch, input logic e);
    result_valid = 1'b1;
    result_data = d;
    active_chan = ch;
    result_err = e;
    ref_missing = e;
    u_amc_host_model.cyc(1);
    result_valid = 1'b0;
    u_amc_host_model.cyc(1);
    chk({31'h0, not_ready}, 32'h0000_0000);
  endtask : post_result

  initial
  begin
    repeat (50000) @(posedge core_clk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    u_amc_host_model.cyc(4);
    rst = 1'b0;
    u_amc_host_model.cyc(4);
    chk({31'h0, not_ready}, 32'h0000_0001);
    chk({31'h0, dout_oe}, 32'h0000_0000);
    check_mode(24'h08_0060);
    post_result(24'h12_3456, 3'h1, 1'b0);
    p0 = pulses;
    u_amc_host_model.write_mode(24'hFF_FFFF, 24);
    chk(pulses - p0, 1);
    chk({31'h0, not_ready}, 32'h0000_0001);
    check_mode(24'hFC_AFFF);
    p0 = pulses;
    u_amc_host_model.write_mode(24'h00_0000, 12);
    chk(pulses - p0, 0);
    check_mode(24'hFC_AFFF);
    u_amc_host_model.write_mode(24'h00_2123, 24);
    post_result(24'hA5_1234, 3'h5, 1'b0);
    u_amc_host_model.frame(8'h58, 24, 32'h0000_0000, rd);
    chk(rd, 32'h00A5_1234);
    chk({31'h0, not_ready}, 32'h0000_0001);
    u_amc_host_model.write_mode(24'h10_2000, 24);
    check_mode(24'h10_2000);
    post_result(24'h00_0007, 3'h6, 1'b1);
    u_amc_host_model.frame(8'h58, 32, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0776);
    u_amc_host_model.frame(8'h40, 8, 32'h0000_0000, rd);
    chk(rd, 32'h0000_00F6);
    u_amc_host_model.frame(8'h50, 24, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    give_verdict();
  end
endmodule : adc_mode_control_register_tb_top
